// ### core/etc_pkg.sv
// Constants, types and register map of the event time counter
//
// Operation
// - A 32-bit counter advances once per active edge of the chosen source.
// - Source is one of digital input lines 0..5 or the internal sample clock.
// - Counter stays idle until armed and then triggered (a trigger while idle is ignored), then counts source edges.
// - Running count is readable at any time without disturbing counting.
// - Held value captures the count on the first latch event only; later ones ignored.
// - Latch select: 0 sample strobe, 1 first event input, 2 second event input.
package etc_pkg;

    localparam int COUNT_W = 32;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DI_LINES = 6;
    localparam int EDGE_W = 9;

    // Bit positions in the edge detector vector
    localparam int EDGE_SAMPLE_POS = 6;
    localparam int EDGE_EV0_POS = 7;
    localparam int EDGE_EV1_POS = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IMMEDIATE = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_LATCHED = 8'h10;

    // Control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_LATCH_LSB = 4;
    localparam int CTRL_FALL_POS = 8;

    // Command register fields, write-only pulses
    localparam int CMD_ARM_POS = 0;
    localparam int CMD_TRIG_POS = 1;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_LATCHED_POS = 2;

    // Source select codes
    localparam logic [2:0] SRC_INTERNAL = 3'h6;

    // Latch select codes
    localparam logic [1:0] LATCH_SAMPLE = 2'h0;
    localparam logic [1:0] LATCH_FIRST_EVENT_INPUT = 2'h1;
    localparam logic [1:0] LATCH_SECOND_EVENT_INPUT = 2'h2;

    // Reset values
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic [1:0] LATCH_RESET = 2'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ETC_IDLE = 2'b00,
        ETC_ARMED = 2'b01,
        ETC_COUNTING = 2'b10
    } etc_state_t;

    typedef struct packed {
        logic src_fall;
        logic [1:0] latch_sel;
        logic [2:0] src_sel;
    } etc_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } etc_bus_req_t;

    localparam etc_ctrl_t CTRL_RESET = '{src_fall: 1'b0, latch_sel: LATCH_RESET, src_sel: SRC_RESET};

endpackage

// ### core/etc_edge_det.sv
// Registered rise and fall detector for a vector of synchronous inputs
`timescale 1ns/1ps
module etc_edge_det (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [etc_pkg::EDGE_W-1:0] level_in, // Input levels
    output logic [etc_pkg::EDGE_W-1:0] rise, // One-cycle pulse per rising edge
    output logic [etc_pkg::EDGE_W-1:0] fall // One-cycle pulse per falling edge
);
    import etc_pkg::*;

    logic [EDGE_W-1:0] last_reg;
    logic [EDGE_W-1:0] rise_reg;
    logic [EDGE_W-1:0] fall_reg;
    logic [EDGE_W-1:0] rise_next;
    logic [EDGE_W-1:0] fall_next;

    always_comb begin
        rise_next = level_in & ~last_reg;
        fall_next = ~level_in & last_reg;
    end

    // Previous level starts low so a high line at reset release shows one rise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_reg <= '0;
            rise_reg <= '0;
            fall_reg <= '0;
        end else begin
            last_reg <= level_in;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise = rise_reg;
    assign fall = fall_reg;

endmodule

// ### core/etc_counter.sv
// Event time counter: source-selected 32-bit count with one-shot event latch
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module etc_counter (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [etc_pkg::DI_LINES-1:0] digital_input_line, // Digital input lines 0..5
    input wire logic sample_clock, // Internal sample clock level
    input wire logic first_event_input, // First event input
    input wire logic second_event_input, // Second event input
    input wire logic acq_arm, // Acquisition armed pulse
    input wire logic acq_trigger, // Acquisition trigger pulse
    input wire logic [etc_pkg::ADDR_W-1:0] reg_addr, // Register byte address
    input wire logic [etc_pkg::DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [etc_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    output logic counting, // Counter running
    output logic latch_done // Held value captured
);
    import etc_pkg::*;

    etc_bus_req_t bus;
    etc_state_t state_reg;
    etc_state_t state_next;
    etc_ctrl_t ctrl_reg;
    etc_ctrl_t ctrl_next;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic [COUNT_W-1:0] held_reg;
    logic [COUNT_W-1:0] held_next;
    logic latched_reg;
    logic latched_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic counting_reg;
    logic counting_next;
    logic [EDGE_W-1:0] edge_levels;
    logic [EDGE_W-1:0] rise;
    logic [EDGE_W-1:0] fall;
    logic src_edge;
    logic latch_event;
    logic arm_any;
    logic trig_any;
    logic wr_cmd;

    // Pick the active source edge for a select code and polarity
    function automatic logic pick_source(
        input logic [2:0] sel,
        input logic use_fall,
        input logic [EDGE_W-1:0] r,
        input logic [EDGE_W-1:0] f
    );
        logic [EDGE_W-1:0] edges;
        logic hit;
        edges = use_fall ? f : r;
        hit = 1'b0;
        if (sel == SRC_INTERNAL) begin
            hit = edges[EDGE_SAMPLE_POS];
        end else if (sel < SRC_INTERNAL) begin
            hit = edges[sel];
        end
        return hit;
    endfunction

    // Map the latch select code onto the event that fires the capture
    function automatic logic pick_latch(
        input logic [1:0] sel,
        input logic [EDGE_W-1:0] r
    );
        logic hit;
        hit = 1'b0;
        unique case (sel)
            LATCH_SAMPLE: begin
                hit = r[EDGE_SAMPLE_POS];
            end
            LATCH_FIRST_EVENT_INPUT: begin
                hit = r[EDGE_EV0_POS];
            end
            LATCH_SECOND_EVENT_INPUT: begin
                hit = r[EDGE_EV1_POS];
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    assign edge_levels = {second_event_input, first_event_input, sample_clock, digital_input_line};

    etc_edge_det u_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .level_in(edge_levels),
        .rise(rise),
        .fall(fall)
    );

    always_comb begin
        wr_cmd = bus.wr && (bus.addr == ADDR_COMMAND);
        arm_any = acq_arm || (wr_cmd && bus.wdata[CMD_ARM_POS]);
        trig_any = acq_trigger || (wr_cmd && bus.wdata[CMD_TRIG_POS]);
        src_edge = pick_source(ctrl_reg.src_sel, ctrl_reg.src_fall, rise, fall);
        latch_event = pick_latch(ctrl_reg.latch_sel, rise);
    end

    // Control register
    always_comb begin
        ctrl_next = ctrl_reg;
        if (bus.wr && (bus.addr == ADDR_CTRL)) begin
            ctrl_next.src_sel = bus.wdata[CTRL_SRC_LSB +: 3];
            ctrl_next.latch_sel = bus.wdata[CTRL_LATCH_LSB +: 2];
            ctrl_next.src_fall = bus.wdata[CTRL_FALL_POS];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Acquisition sequence; arm wins over a trigger in the same cycle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ETC_IDLE: begin
                if (arm_any) begin
                    state_next = ETC_ARMED;
                end
            end
            ETC_ARMED: begin
                if (arm_any) begin
                    state_next = ETC_ARMED;
                end else if (trig_any) begin
                    state_next = ETC_COUNTING;
                end
            end
            ETC_COUNTING: begin
                if (arm_any) begin
                    state_next = ETC_ARMED;
                end
            end
            default: begin
                state_next = ETC_IDLE;
            end
        endcase
        counting_next = (state_next == ETC_COUNTING);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ETC_IDLE;
            counting_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            counting_reg <= counting_next;
        end
    end

    // Running count and one-time capture
    always_comb begin
        count_next = count_reg;
        held_next = held_reg;
        latched_next = latched_reg;
        if (arm_any) begin
            count_next = COUNT_RESET;
            held_next = COUNT_RESET;
            latched_next = 1'b0;
        end else if (state_reg == ETC_COUNTING) begin
            if (src_edge) begin
                count_next = count_reg + 32'h0000_0001;
            end
            if (latch_event && !latched_reg) begin
                held_next = count_reg;
                latched_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= COUNT_RESET;
            held_reg <= COUNT_RESET;
            latched_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            held_reg <= held_next;
            latched_reg <= latched_next;
        end
    end

    // Read port; reads have no side effects on the counter
    always_comb begin
        rdata_next = RDATA_RESET;
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_CTRL: begin
                    rdata_next[CTRL_SRC_LSB +: 3] = ctrl_reg.src_sel;
                    rdata_next[CTRL_LATCH_LSB +: 2] = ctrl_reg.latch_sel;
                    rdata_next[CTRL_FALL_POS] = ctrl_reg.src_fall;
                end
                ADDR_STATUS: begin
                    rdata_next[STAT_STATE_LSB +: 2] = state_reg;
                    rdata_next[STAT_LATCHED_POS] = latched_reg;
                end
                ADDR_IMMEDIATE: begin
                    rdata_next = count_reg;
                end
                ADDR_LATCHED: begin
                    rdata_next = held_reg;
                end
                default: begin
                    rdata_next = RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign counting = counting_reg;
    assign latch_done = latched_reg;

endmodule

// ### test/etc_src_model.sv
// Far-side model: count source lines, sample clock and event lines
`timescale 1ns/1ps
module etc_src_model (
    input wire logic clk_sys, // System clock
    output logic [etc_pkg::DI_LINES-1:0] digital_input_line, // Count lines
    output logic sample_clock, // Sample clock level
    output logic first_event_input, // First event line
    output logic second_event_input // Second event line
);
    import etc_pkg::*;
    logic [EDGE_W-1:0] lv = '0;
    assign {second_event_input, first_event_input, sample_clock, digital_input_line} = lv;
    task automatic pulse(input int idx, input int width);
        @(posedge clk_sys);
        lv[idx] <= 1'b1;
        repeat (width) @(posedge clk_sys);
        lv[idx] <= 1'b0;
    endtask
endmodule

// ### test/etc_counter_assertions.sv
// Port-level checker for the event time counter
`timescale 1ns/1ps
module etc_counter_checker (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic sample_clock, // Sample clock
    input wire logic first_event_input, // Event line 1
    input wire logic second_event_input, // Event line 2
    input wire logic acq_arm, // Arm
    input wire logic acq_trigger, // Trigger
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [etc_pkg::DATA_W-1:0] reg_rdata, // Read data
    input wire logic counting, // Running
    input wire logic latch_done // Captured
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_arm_clear;
        acq_arm |=> !counting && !latch_done;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm did not clear");
    property p_trig_start;
        acq_arm ##1 (acq_trigger && !acq_arm) |=> counting;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
    property p_start_cause;
        $rose(counting) |-> $past(acq_trigger) || $past(reg_wr);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without trigger");
    property p_count_hold;
        counting && !acq_arm && !reg_wr |=> counting;
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counting stopped");
    property p_latch_hold;
        latch_done && !acq_arm && !reg_wr |=> latch_done;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("capture flag lost");
    property p_latch_cause;
        $rose(latch_done) |-> ($past(sample_clock, 2) && !$past(sample_clock, 3))
            || ($past(first_event_input, 2) && !$past(first_event_input, 3))
            || ($past(second_event_input, 2) && !$past(second_event_input, 3));
    endproperty
    a_latch_cause: assert property (p_latch_cause) else $error("capture without event");
endmodule
bind etc_counter etc_counter_checker u_etc_counter_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .sample_clock(sample_clock), .first_event_input(first_event_input), .second_event_input(second_event_input),
    .acq_arm(acq_arm), .acq_trigger(acq_trigger), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .counting(counting), .latch_done(latch_done));

// ### test/etc_counter_tb_top.sv
// Self-checking bench for the event time counter
`timescale 1ns/1ps
module etc_counter_tb_top;
    import etc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic acq_arm = 1'b0;
    logic acq_trigger = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DI_LINES-1:0] digital_input_line;
    logic sample_clock;
    logic first_event_input;
    logic second_event_input;
    logic counting;
    logic latch_done;
    int fail_count = 0;
    int compares = 0;
    always #12.5 clk_sys = ~clk_sys;
    etc_src_model u_etc_src_model (.clk_sys(clk_sys), .digital_input_line(digital_input_line),
        .sample_clock(sample_clock), .first_event_input(first_event_input), .second_event_input(second_event_input));
    etc_counter u_etc_counter (.clk_sys(clk_sys), .rst_n(rst_n), .digital_input_line(digital_input_line),
        .sample_clock(sample_clock), .first_event_input(first_event_input), .second_event_input(second_event_input),
        .acq_arm(acq_arm), .acq_trigger(acq_trigger), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .counting(counting), .latch_done(latch_done));
    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic pins(input logic a, input logic t);
        @(posedge clk_sys);
        acq_arm <= a;
        acq_trigger <= t;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_rd(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        compares++;
        if (reg_rdata !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, reg_rdata);
        end
    endtask
    task automatic chk_bit(input string name, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk_rd("ctrl", ADDR_CTRL, 32'h0000_0000);
        chk_rd("status", ADDR_STATUS, 32'h0000_0000);
        wr(ADDR_IMMEDIATE, 32'h0000_00FF);
        chk_rd("count ro", ADDR_IMMEDIATE, 32'h0000_0000);
        chk_rd("unmapped", 8'h14, 32'h0000_0000);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        chk_rd("idle trigger", ADDR_STATUS, 32'h0000_0000);
        chk_bit("counting", counting, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        u_etc_src_model.pulse(0, 1);
        chk_rd("armed count", ADDR_IMMEDIATE, 32'h0000_0000);
        chk_rd("armed", ADDR_STATUS, 32'h0000_0001);
        chk_bit("counting", counting, 1'b0);
        chk_bit("latch_done", latch_done, 1'b0);
        $display("test idle done");
        for (int s = 0; s < 7; s++) begin
            wr(ADDR_CTRL, DATA_W'(s));
            pins(1'b1, 1'b0);
            pins(1'b0, 1'b1);
            pins(1'b0, 1'b0);
            chk_rd("running", ADDR_STATUS, 32'h0000_0002);
            chk_bit("counting", counting, 1'b1);
            repeat (3) u_etc_src_model.pulse(s, s + 1);
            // Unselected line must not count
            u_etc_src_model.pulse((s + 1) % 7, 1);
            chk_rd("count", ADDR_IMMEDIATE, 32'h0000_0003);
        end
        $display("test source done");
        for (int e = 0; e < 3; e++) begin
            wr(ADDR_CTRL, DATA_W'(e) << CTRL_LATCH_LSB);
            wr(ADDR_COMMAND, 32'h0000_0001);
            wr(ADDR_COMMAND, 32'h0000_0002);
            repeat (2) u_etc_src_model.pulse(0, 1);
            u_etc_src_model.pulse(EDGE_SAMPLE_POS + (e + 1) % 3, 1);
            chk_rd("no capture", ADDR_STATUS, 32'h0000_0002);
            chk_bit("latch_done", latch_done, 1'b0);
            u_etc_src_model.pulse(EDGE_SAMPLE_POS + e, 1);
            u_etc_src_model.pulse(0, 2);
            u_etc_src_model.pulse(EDGE_SAMPLE_POS + e, 1);
            chk_rd("held", ADDR_LATCHED, 32'h0000_0002);
            chk_rd("captured", ADDR_STATUS, 32'h0000_0006);
            chk_bit("latch_done", latch_done, 1'b1);
            chk_rd("live", ADDR_IMMEDIATE, 32'h0000_0003);
        end
        $display("test capture done");
        // Falling edges of line 0, no latch event selected
        wr(ADDR_CTRL, 32'h0000_0130);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
        repeat (2) u_etc_src_model.pulse(0, 1);
        // A fall reaches the count two cycles after the line drops
        pins(1'b0, 1'b0);
        chk_rd("fall count", ADDR_IMMEDIATE, 32'h0000_0002);
        // Source code 7 and latch code 3 select nothing
        wr(ADDR_CTRL, 32'h0000_0037);
        chk_rd("ctrl rw", ADDR_CTRL, 32'h0000_0037);
        for (int n = 0; n < 3; n++) begin
            u_etc_src_model.pulse(EDGE_SAMPLE_POS + n, 1);
        end
        u_etc_src_model.pulse(0, 1);
        chk_rd("no source", ADDR_IMMEDIATE, 32'h0000_0002);
        chk_rd("no latch", ADDR_STATUS, 32'h0000_0002);
        chk_bit("latch_done", latch_done, 1'b0);
        $display("test mode done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        test_done();
    end
endmodule
